// [dfs_far_model.sv]
// far-side model: sensing comparators and the power stage contactor
`timescale 1ns/1ps

module dfs_far_model (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire dfs_pkg::dfs_pin_flags_t flag_req,
    input  wire logic                    motor_power_en,
    output dfs_pkg::dfs_pin_flags_t      flags_pin,
    output logic                         stage_live
);
    import dfs_pkg::*;

    // ============================================================
    // comparators
    // flags settle off the clock, so the supervisor must synchronise them;
    // one process owns the pins so they start low and have a single driver
    initial begin
        flags_pin = '0;
        forever begin
            @(flag_req);
            flags_pin <= #7 flag_req;
        end
    end

    // contactor follows the permit one cycle late, dead while in reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage_live <= 1'b0;
        end else begin
            stage_live <= motor_power_en;
        end
    end
endmodule

// [dfs_glyph_rom.sv]
// glyph to seven-segment pattern table with registered read data
`timescale 1ns/1ps
`include "dfs_map.svh"

module dfs_glyph_rom (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] glyph,
    output logic      [7:0] pattern
);
    logic [7:0] pattern_next;

    // ============================================================
    // table lookup
    always_comb begin
        case (glyph)
            4'h0:             pattern_next = `DFS_SEG_0;
            4'h1:             pattern_next = `DFS_SEG_1;
            4'h2:             pattern_next = `DFS_SEG_2;
            4'h3:             pattern_next = `DFS_SEG_3;
            4'h4:             pattern_next = `DFS_SEG_4;
            4'h5:             pattern_next = `DFS_SEG_5;
            4'h6:             pattern_next = `DFS_SEG_6;
            4'h7:             pattern_next = `DFS_SEG_7;
            4'h8:             pattern_next = `DFS_SEG_8;
            4'h9:             pattern_next = `DFS_SEG_9;
            `DFS_GLYPH_F:     pattern_next = `DFS_SEG_F;
            default:          pattern_next = `DFS_SEG_BLANK;
        endcase
    end

    // read data register, dark display after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pattern <= `DFS_SEG_BLANK;
        end else begin
            pattern <= pattern_next;
        end
    end

endmodule

// [dfs_map.svh]
// constant map of the drive fault supervisor: codes, limits, timing, glyphs
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH

// ============================================================
// fault codes
`define DFS_CODE_HW_DEFECT   4'h0
`define DFS_CODE_SUPPLY      4'h1
`define DFS_CODE_PHASE       4'h2
`define DFS_CODE_CABLE       4'h3
`define DFS_CODE_DC_OVER     4'h4
`define DFS_CODE_CUR_OVER    4'h5
`define DFS_CODE_BALLAST     4'h6
`define DFS_CODE_DEV_TEMP    4'h7
`define DFS_CODE_MOTOR_TEMP  4'h8
`define DFS_CODE_ENCODER     4'h9
`define DFS_CODE_OVERSPEED   4'ha
`define DFS_CODE_OVERRANGE   4'hb
`define DFS_CODE_TENS        4'ha

// ============================================================
// trip limits
`define DFS_DC_LINK_MAX_V    12'h0352
`define DFS_CUR_NUM          19'h0_0005
`define DFS_CUR_DEN          19'h0_0002
`define DFS_SPD_NUM          19'h0_0005
`define DFS_SPD_DEN          19'h0_0004

// ============================================================
// timing
`define DFS_CLK_HZ           40000000
`define DFS_REFRESH_MS       1000
`define DFS_REFRESH_CYCLES   (`DFS_CLK_HZ / 1000 * `DFS_REFRESH_MS)
`define DFS_TIMER_W          26

// ============================================================
// display glyphs and segment patterns, bit order dp g f e d c b a
`define DFS_GLYPH_F          4'hf
`define DFS_GLYPH_BLANK      4'he
`define DFS_SEG_F            8'h71
`define DFS_SEG_BLANK        8'h00
`define DFS_SEG_0            8'h3f
`define DFS_SEG_1            8'h06
`define DFS_SEG_2            8'h5b
`define DFS_SEG_3            8'h4f
`define DFS_SEG_4            8'h66
`define DFS_SEG_5            8'h6d
`define DFS_SEG_6            8'h7d
`define DFS_SEG_7            8'h07
`define DFS_SEG_8            8'h7f
`define DFS_SEG_9            8'h6f

`endif

// [dfs_pkg.sv]
// types shared by the drive fault supervisor files
package dfs_pkg;

    // ============================================================
    // comparator flags arriving on pins, all active high
    typedef struct packed {
        logic hw_defect;
        logic supply_bad;
        logic phase_loss;
        logic cable_open;
        logic ballast_ovl;
        logic dev_temp_max;
        logic motor_temp_max;
        logic enc_break;
        logic enc_init_fail;
        logic cur_overrange;
    } dfs_pin_flags_t;

    // ============================================================
    // measurement words from logic on the same clock
    typedef struct packed {
        logic [11:0] dc_link_volts;
        logic [15:0] out_current;
        logic [15:0] rated_current;
        logic [15:0] shaft_speed;
        logic [15:0] max_speed;
    } dfs_meas_t;

    // ============================================================
    // latched fault
    typedef struct packed {
        logic       active;
        logic [3:0] code;
    } dfs_fault_t;

    // ============================================================
    // display phase
    typedef enum logic [3:0] {
        DISP_BLANK = 4'b0001,
        DISP_F     = 4'b0010,
        DISP_TENS  = 4'b0100,
        DISP_UNITS = 4'b1000
    } dfs_disp_state_t;

endpackage

// [dfs_supervisor.sv]
// drive fault supervisor: fault detection, latching, power cut and display
// What this block does
// RULE1: latched fault shows F, tens, units, per second
// RULE2: defect code 00, supply code 01, never acknowledged
// RULE3: mains phase loss latches 02, cuts power
// RULE4: first enable tests cable; broken latches 03
// RULE5: DC link above 850 V latches 04
// RULE6: current above 2.5 times rated latches 05
// RULE7: ballast overload latches 06, cuts power
// RULE8: amplifier at maximum temperature latches 07
// RULE9: motor at maximum temperature latches 08
// RULE10: encoder break or init failure latches 09
// RULE11: speed above 1.25 times maximum latches 10
// RULE12: current overrange peak latches 11, cuts power
// RULE13: acknowledge clears codes 02+ once condition gone
`timescale 1ns/1ps
`include "dfs_map.svh"

module dfs_supervisor #(
    parameter int unsigned REFRESH_CYCLES = `DFS_REFRESH_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire dfs_pkg::dfs_pin_flags_t flags_pin,
    input  wire dfs_pkg::dfs_meas_t      meas,
    input  wire logic                    drive_enable,
    input  wire logic                    fault_ack,
    output logic                         motor_power_en,
    output logic                         fault_active,
    output logic [3:0]                   fault_code,
    output logic [7:0]                   seg_pattern
);
    import dfs_pkg::*;

    // ============================================================
    // helpers
    // lowest code wins when several faults appear in one cycle
    function automatic logic [3:0] first_fault(input logic [11:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                c = 4'(i);
            end
        end
        return c;
    endfunction

    // ============================================================
    // pin synchronisers
    dfs_pin_flags_t flags_s;

    // each flag passes two flops; the first is read only by the second
    generate
        for (genvar i = 0; i < $bits(dfs_pin_flags_t); i++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                end else begin
                    s1_reg <= flags_pin[i];
                    s2_reg <= s1_reg;
                end
            end
            assign flags_s[i] = s2_reg;
        end
    endgenerate

    // ============================================================
    // fault detection and latch
    dfs_fault_t  fault_reg;
    dfs_fault_t  fault_next;
    logic        power_reg;
    logic        power_next;
    logic        cable_tested_reg;
    logic        cable_tested_next;
    logic        en_prev_reg;
    logic        en_prev_next;
    logic        first_enable;
    logic        dc_over;
    logic        cur_over;
    logic        spd_over;
    logic        clear_ok;
    logic [11:0] cond_now;
    logic [11:0] hold_cond;

    // trip comparisons; ratios are cross-multiplied so no divider is needed
    always_comb begin
        dc_over  = meas.dc_link_volts > `DFS_DC_LINK_MAX_V;                  // RULE5
        cur_over = 19'(meas.out_current) * `DFS_CUR_DEN
                 > 19'(meas.rated_current) * `DFS_CUR_NUM;                   // RULE6
        spd_over = 19'(meas.shaft_speed) * `DFS_SPD_DEN
                 > 19'(meas.max_speed) * `DFS_SPD_NUM;                       // RULE11
        first_enable = drive_enable && !en_prev_reg && !cable_tested_reg;   // RULE4
    end

    // next fault state; a new fault in the acknowledge cycle is still taken
    always_comb begin
        cond_now = '0;
        cond_now[`DFS_CODE_HW_DEFECT]  = flags_s.hw_defect;                 // RULE2
        cond_now[`DFS_CODE_SUPPLY]     = flags_s.supply_bad;                // RULE2
        cond_now[`DFS_CODE_PHASE]      = flags_s.phase_loss;                // RULE3
        cond_now[`DFS_CODE_CABLE]      = first_enable && flags_s.cable_open; // RULE4
        cond_now[`DFS_CODE_DC_OVER]    = dc_over;                           // RULE5
        cond_now[`DFS_CODE_CUR_OVER]   = cur_over;                          // RULE6
        cond_now[`DFS_CODE_BALLAST]    = flags_s.ballast_ovl;               // RULE7
        cond_now[`DFS_CODE_DEV_TEMP]   = flags_s.dev_temp_max;              // RULE8
        cond_now[`DFS_CODE_MOTOR_TEMP] = flags_s.motor_temp_max;            // RULE9
        cond_now[`DFS_CODE_ENCODER]    = flags_s.enc_break
                                      || flags_s.enc_init_fail;             // RULE10
        cond_now[`DFS_CODE_OVERSPEED]  = spd_over;                          // RULE11
        cond_now[`DFS_CODE_OVERRANGE]  = flags_s.cur_overrange;             // RULE12
        // a broken cable still counts as present after the test
        hold_cond = cond_now;
        hold_cond[`DFS_CODE_CABLE] = flags_s.cable_open;
        clear_ok = fault_ack && fault_reg.active
                && fault_reg.code > `DFS_CODE_SUPPLY
                && !hold_cond[fault_reg.code];                              // RULE13
        fault_next = fault_reg;
        if (clear_ok) begin
            fault_next = '0;
        end
        if ((!fault_reg.active || clear_ok) && |cond_now) begin
            fault_next.active = 1'b1;
            fault_next.code   = first_fault(cond_now);
        end
        cable_tested_next = cable_tested_reg || first_enable;
        en_prev_next      = drive_enable;
        // power drops on the same edge the fault is latched
        power_next = drive_enable && !fault_next.active;                    // RULE3
    end

    // fault registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_reg        <= '0;
            power_reg        <= 1'b0;
            cable_tested_reg <= 1'b0;
            en_prev_reg      <= 1'b0;
        end else begin
            fault_reg        <= fault_next;
            power_reg        <= power_next;
            cable_tested_reg <= cable_tested_next;
            en_prev_reg      <= en_prev_next;
        end
    end

    assign motor_power_en = power_reg;
    assign fault_active   = fault_reg.active;
    assign fault_code     = fault_reg.code;

    // ============================================================
    // display sequencer
    dfs_disp_state_t             disp_reg;
    dfs_disp_state_t             disp_next;
    logic [`DFS_TIMER_W-1:0]     timer_reg;
    logic [`DFS_TIMER_W-1:0]     timer_next;
    logic                        tick;
    logic [3:0]                  glyph_sel;

    // one glyph per second: F, tens digit, units digit, then again
    always_comb begin
        tick       = timer_reg == `DFS_TIMER_W'(REFRESH_CYCLES - 1);
        timer_next = tick ? '0 : timer_reg + `DFS_TIMER_W'(1);
        disp_next  = disp_reg;
        if (!fault_next.active) begin
            disp_next  = DISP_BLANK;                                        // RULE13
            timer_next = '0;
        end else if (!fault_reg.active || fault_next.code != fault_reg.code) begin
            disp_next  = DISP_F;                                            // RULE1
            timer_next = '0;
        end else if (tick) begin
            case (disp_reg)
                DISP_F:     disp_next = DISP_TENS;                          // RULE1
                DISP_TENS:  disp_next = DISP_UNITS;
                DISP_UNITS: disp_next = DISP_F;
                default:    disp_next = DISP_F;
            endcase
        end
    end

    // display registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            disp_reg  <= DISP_BLANK;
            timer_reg <= '0;
        end else begin
            disp_reg  <= disp_next;
            timer_reg <= timer_next;
        end
    end

    // glyph choice; codes stop at 11 so tens is 0 or 1
    always_comb begin
        case (disp_reg)
            DISP_F:     glyph_sel = `DFS_GLYPH_F;
            DISP_TENS:  glyph_sel = (fault_reg.code >= `DFS_CODE_TENS) ? 4'h1 : 4'h0;
            DISP_UNITS: glyph_sel = (fault_reg.code >= `DFS_CODE_TENS)
                                  ? fault_reg.code - `DFS_CODE_TENS : fault_reg.code;
            default:    glyph_sel = `DFS_GLYPH_BLANK;
        endcase
    end

    dfs_glyph_rom u_rom (
        .clk     (clk),
        .resetn  (resetn),
        .glyph   (glyph_sel),
        .pattern (seg_pattern)
    );

    // ============================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_r1_seq;
        fault_reg.active && fault_next.active && fault_next.code == fault_reg.code
            && tick && disp_reg == DISP_F
            |=> disp_reg == DISP_TENS ##1 seg_pattern != `DFS_SEG_F;
    endproperty
    a_r1_seq: assert property (p_r1_seq) else $error("display did not step after F"); // RULE1

    property p_r1_start;
        !fault_reg.active && |cond_now |=> disp_reg == DISP_F ##1 seg_pattern == `DFS_SEG_F;
    endproperty
    a_r1_start: assert property (p_r1_start) else $error("new fault did not show F"); // RULE1

    property p_r2_latch;
        !fault_reg.active && flags_s.hw_defect
            |=> fault_reg.active && fault_reg.code == `DFS_CODE_HW_DEFECT && !motor_power_en;
    endproperty
    a_r2_latch: assert property (p_r2_latch) else $error("defect not latched as 00"); // RULE2

    property p_r2_sticky;
        fault_reg.active && fault_reg.code <= `DFS_CODE_SUPPLY
            |=> fault_reg.active && $stable(fault_reg.code);
    endproperty
    a_r2_sticky: assert property (p_r2_sticky) else $error("code 00 or 01 was cleared"); // RULE2

    property p_r3_phase;
        !fault_reg.active && first_fault(cond_now) == `DFS_CODE_PHASE && flags_s.phase_loss
            |=> fault_reg.code == `DFS_CODE_PHASE && !motor_power_en;
    endproperty
    a_r3_phase: assert property (p_r3_phase) else $error("phase loss not latched"); // RULE3

    property p_r4_cable;
        !fault_reg.active && cond_now[2:0] == 3'h0 && drive_enable && !en_prev_reg
            && !cable_tested_reg && flags_s.cable_open
            |=> fault_reg.code == `DFS_CODE_CABLE && !motor_power_en ##1 cable_tested_reg;
    endproperty
    a_r4_cable: assert property (p_r4_cable) else $error("cable test missed"); // RULE4

    property p_r5_dc;
        !fault_reg.active && cond_now[3:0] == 4'h0 && meas.dc_link_volts > 12'h0352
            |=> fault_reg.code == `DFS_CODE_DC_OVER && !motor_power_en;
    endproperty
    a_r5_dc: assert property (p_r5_dc) else $error("DC link overvoltage not latched"); // RULE5

    property p_r6_cur;
        !fault_reg.active && cond_now[4:0] == 5'h00
            && 2 * int'(meas.out_current) > 5 * int'(meas.rated_current)
            |=> fault_reg.code == `DFS_CODE_CUR_OVER && !motor_power_en;
    endproperty
    a_r6_cur: assert property (p_r6_cur) else $error("overcurrent not latched"); // RULE6

    property p_r7_ballast;
        !fault_reg.active && first_fault(cond_now) == `DFS_CODE_BALLAST && |cond_now
            |=> fault_reg.code == `DFS_CODE_BALLAST && !motor_power_en;
    endproperty
    a_r7_ballast: assert property (p_r7_ballast) else $error("ballast fault lost"); // RULE7

    property p_r8_devtemp;
        !fault_reg.active && cond_now[6:0] == 7'h00 && flags_s.dev_temp_max
            |=> fault_reg.code == `DFS_CODE_DEV_TEMP && !motor_power_en;
    endproperty
    a_r8_devtemp: assert property (p_r8_devtemp) else $error("device heat not latched"); // RULE8

    property p_r9_motortemp;
        !fault_reg.active && cond_now[7:0] == 8'h00 && flags_s.motor_temp_max
            |=> fault_reg.code == `DFS_CODE_MOTOR_TEMP && !motor_power_en;
    endproperty
    a_r9_motortemp: assert property (p_r9_motortemp) else $error("motor heat lost"); // RULE9

    property p_r10_enc;
        !fault_reg.active && cond_now[8:0] == 9'h000 && flags_s.enc_init_fail
            |=> fault_reg.code == `DFS_CODE_ENCODER && !motor_power_en;
    endproperty
    a_r10_enc: assert property (p_r10_enc) else $error("encoder fault not latched"); // RULE10

    property p_r11_speed;
        !fault_reg.active && cond_now[9:0] == 10'h000
            && 4 * int'(meas.shaft_speed) > 5 * int'(meas.max_speed)
            |=> fault_reg.code == `DFS_CODE_OVERSPEED && !motor_power_en;
    endproperty
    a_r11_speed: assert property (p_r11_speed) else $error("overspeed not latched"); // RULE11

    property p_r12_range;
        !fault_reg.active && cond_now[10:0] == 11'h000 && flags_s.cur_overrange
            |=> fault_reg.code == `DFS_CODE_OVERRANGE && !motor_power_en;
    endproperty
    a_r12_range: assert property (p_r12_range) else $error("overrange not latched"); // RULE12

    property p_r13_clear;
        fault_ack && fault_reg.active && fault_reg.code > `DFS_CODE_SUPPLY
            && !hold_cond[fault_reg.code] && cond_now == 12'h000
            |=> !fault_reg.active ##1 seg_pattern == `DFS_SEG_BLANK;
    endproperty
    a_r13_clear: assert property (p_r13_clear) else $error("acknowledge did not clear"); // RULE13

    property p_r13_hold;
        fault_reg.active && !fault_ack |=> fault_reg.active && $stable(fault_reg.code);
    endproperty
    a_r13_hold: assert property (p_r13_hold) else $error("fault dropped without ack"); // RULE13

endmodule

// [dfs_supervisor_bench.sv]
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ps

module dfs_supervisor_bench;
    import dfs_pkg::*;

    localparam int unsigned R = 8;
    logic           clk;
    logic           resetn;
    dfs_pin_flags_t flag_req;
    dfs_pin_flags_t flags_pin;
    dfs_meas_t      meas;
    logic           drive_enable;
    logic           fault_ack;
    logic           motor_power_en;
    logic           fault_active;
    logic [3:0]     fault_code;
    logic [7:0]     seg_pattern;
    logic           stage_live;
    int             err_count;
    int             check_count;
    // digit patterns, and code for each flag bit from lsb up
    logic [7:0]     digs [10] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66,
                                  8'h6d, 8'h7d, 8'h07, 8'h7f, 8'h6f};
    logic [3:0]     pin_code [10] = '{4'hb, 4'h9, 4'h9, 4'h8, 4'h7,
                                      4'h6, 4'h3, 4'h2, 4'h1, 4'h0};
    logic [15:0]    lim [3] = '{16'h0352, 16'h00fa, 16'h007d};
    logic [3:0]     mcode [3] = '{4'h4, 4'h5, 4'ha};

    // ============================================================
    // design and far side
    dfs_supervisor #(.REFRESH_CYCLES(R)) uut (
        .clk            (clk),
        .resetn         (resetn),
        .flags_pin      (flags_pin),
        .meas           (meas),
        .drive_enable   (drive_enable),
        .fault_ack      (fault_ack),
        .motor_power_en (motor_power_en),
        .fault_active   (fault_active),
        .fault_code     (fault_code),
        .seg_pattern    (seg_pattern)
    );
    dfs_far_model far (
        .clk            (clk),
        .resetn         (resetn),
        .flag_req       (flag_req),
        .motor_power_en (motor_power_en),
        .flags_pin      (flags_pin),
        .stage_live     (stage_live)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ============================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        flag_req = '0;
        meas = '0;
        meas.rated_current = 16'h0064;
        meas.max_speed = 16'h0064;
        drive_enable = 1'b0;
        fault_ack = 1'b0;
        tick(3);
        resetn = 1'b1;
        tick(1);
        chk(seg_pattern, 8'h00);
        chk({3'h0, fault_active, fault_code}, 8'h00);
        drive_enable = 1'b1;
        tick(3);
        chk({6'h00, motor_power_en, stage_live}, 8'h03);
    endtask

    // latched code and power removed, bounded by the sync delay
    task automatic wait_latch(input logic [3:0] code);
        int i;
        for (i = 0; i < 8 && fault_active !== 1'b1; i++) tick(1);
        chk({3'h0, fault_active, fault_code}, {4'h1, code});
        chk({7'h00, motor_power_en}, 8'h00);
    endtask

    // F, tens, units, each held R cycles, then F again
    task automatic disp_chk(input logic [3:0] code);
        int i;
        for (i = 0; i < 8 && seg_pattern !== 8'h71; i++) tick(1);
        chk(seg_pattern, 8'h71);
        tick(R);
        chk(seg_pattern, digs[code / 10]);
        tick(R);
        chk(seg_pattern, digs[code % 10]);
        tick(R);
        chk(seg_pattern, 8'h71);
    endtask

    task automatic try_ack(input logic clear);
        fault_ack = 1'b1;
        tick(1);
        fault_ack = 1'b0;
        chk({7'h00, fault_active}, {7'h00, !clear});
        tick(1);
        if (clear) begin
            chk({fault_code, 4'h0}, 8'h00);
            chk(seg_pattern, 8'h00);
        end
    endtask

    // ============================================================
    // scenarios
    task automatic test_pins();
        int b;
        for (b = 0; b < 10; b++) begin
            if (b != 6) begin
                do_reset();
                flag_req = dfs_pin_flags_t'(10'h001 << b);
                wait_latch(pin_code[b]);
                disp_chk(pin_code[b]);
                try_ack(1'b0);
                flag_req = '0;
                tick(4);
                try_ack(pin_code[b] > 4'h1);
            end
        end
        $display("test_pins done");
    endtask

    // cable checked on the first enable only
    task automatic test_cable();
        resetn = 1'b0;
        tick(1);
        do_reset();
        drive_enable = 1'b0;
        tick(1);
        resetn = 1'b0;
        tick(1);
        resetn = 1'b1;
        flag_req.cable_open = 1'b1;
        tick(4);
        drive_enable = 1'b1;
        wait_latch(4'h3);
        flag_req = '0;
        tick(4);
        try_ack(1'b1);
        do_reset();
        drive_enable = 1'b0;
        flag_req.cable_open = 1'b1;
        tick(4);
        drive_enable = 1'b1;
        tick(4);
        chk({7'h00, fault_active}, 8'h00);
        $display("test_cable done");
    endtask

    // trip strictly above each limit, at the same edge
    task automatic test_meas();
        int s;
        for (s = 0; s < 3; s++) begin
            do_reset();
            meas.dc_link_volts = (s == 0) ? lim[0][11:0] : 12'h000;
            meas.out_current = (s == 1) ? lim[1] : 16'h0000;
            meas.shaft_speed = (s == 2) ? lim[2] : 16'h0000;
            tick(3);
            chk({7'h00, fault_active}, 8'h00);
            meas.dc_link_volts = meas.dc_link_volts + {11'h000, s == 0};
            meas.out_current = meas.out_current + {15'h0000, s == 1};
            meas.shaft_speed = meas.shaft_speed + {15'h0000, s == 2};
            tick(1);
            chk({7'h00, fault_active}, 8'h01);
            wait_latch(mcode[s]);
            disp_chk(mcode[s]);
            meas.dc_link_volts = 12'h000;
            meas.out_current = 16'h0000;
            meas.shaft_speed = 16'h0000;
            try_ack(1'b1);
        end
        $display("test_meas done");
    endtask

    // lowest code wins, first fault kept, set wins over acknowledge
    task automatic test_order();
        do_reset();
        flag_req.dev_temp_max = 1'b1;
        flag_req.phase_loss = 1'b1;
        wait_latch(4'h2);
        flag_req.ballast_ovl = 1'b1;
        flag_req.hw_defect = 1'b1;
        tick(4);
        chk({4'h0, fault_code}, 8'h02);
        flag_req = '0;
        flag_req.ballast_ovl = 1'b1;
        tick(4);
        fault_ack = 1'b1;
        tick(1);
        fault_ack = 1'b0;
        tick(2);
        chk({3'h0, fault_active, fault_code}, 8'h16);
        $display("test_order done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        err_count = 0;
        check_count = 0;
        resetn = 1'b0;
        flag_req = '0;
        meas = '0;
        drive_enable = 1'b0;
        fault_ack = 1'b0;
        tick(3);
        test_pins();
        test_cable();
        test_meas();
        test_order();
        stop_test();
    end

    // whole run is under a thousand cycles; this is far beyond it
    initial begin
        #2_000_000;
        err_count++;
        stop_test();
    end
endmodule
